// >>> rtl/gpcc_top.v
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "gpcc_regs.vh"
module gpcc_top #(
  parameter SEC_DIV = `GPCC_CLK_HZ
) (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_RST_N,
  // nonvolatile storage read port, data one cycle later
  output reg  [7:0]  O_NV_ADDR,
  output reg         O_NV_RD,
  input  wire [7:0]  I_NV_DATA,
  // register port
  input  wire [7:0]  I_ADDR,
  input  wire [7:0]  I_WDATA,
  input  wire        I_WR,
  input  wire        I_RD,
  output reg  [7:0]  O_RDATA,
  // measurements
  input  wire        I_CHARGING,
  input  wire        I_FAST_TERM,
  input  wire [15:0] I_PACK_MV,
  input  wire [15:0] I_CHG_VOLT_MV,
  input  wire [15:0] I_CURRENT_MA,
  input  wire [15:0] I_CELL_MAX_MV,
  input  wire [15:0] I_CELL_MIN_MV,
  input  wire [15:0] I_FCC,
  input  wire        I_DSG_MAH_TICK,
  input  wire [15:0] I_TEMP_DK,
  input  wire [15:0] I_MAXTEMP_DK,
  input  wire        I_OVERTEMP,
  input  wire        I_AFE_CHECK_FAIL,
  input  wire        I_SMB_LOW,
  input  wire        I_PRECHG_COND,
  input  wire        I_CHG_FET_REQ,
  input  wire        I_DSG_FET_REQ,
  input  wire        I_MIDRANGE_REQ,
  // decoded configuration and control outputs
  output reg         O_READY,
  output reg         O_DISPLAY_SOC_SELECT,
  output reg  [2:0]  O_DISPLAY_SEGMENT_COUNT,
  output reg         O_LED_ENABLE,
  output reg         O_HOST_ALARM_CRC_ENABLE,
  output reg         O_CHARGER_BROADCAST_CRC_ENABLE,
  output reg         O_BROADCAST_ENABLE,
  output reg  [2:0]  O_SERIES_CELL_COUNT,
  output reg         O_COMPENSATED_THRESHOLD_ENABLE,
  output reg         O_END_DISCHARGE_VOLT_SOURCE,
  output reg         O_SAFETY_OVERVOLT_SOURCE,
  output reg         O_MIDRANGE_CORRECT,
  output reg         O_RM_LOAD,
  output reg  [15:0] O_RM_VALUE,
  output reg  [15:0] O_CYCLE_COUNT,
  output reg         O_TAPER_TERM,
  output reg         O_BALANCE,
  output reg         O_AFE_FAIL,
  output reg         O_SAFE,
  output reg         O_SLEEP,
  output reg         O_CHG_FET,
  output reg         O_DSG_FET,
  output reg         O_PRECHG_FET,
  output reg         O_TEMP_SUSPEND
);
  // power-up load machine
  localparam ST_LOAD = 2'h0;
  localparam ST_RUN  = 2'h1;

  localparam integer TAPER_CYC = `GPCC_TAPER_S;
  localparam integer SLEEP_CYC = `GPCC_SLEEP_S;
  localparam integer DELAY_CYC = `GPCC_DELAY_S;

  reg  [1:0]  state_reg;
  reg  [4:0]  ld_idx_reg;
  reg  [4:0]  ld_idx_d_reg;
  reg         ld_vld_reg;
  reg  [7:0]  pack_option_byte_reg;
  reg  [7:0]  gauge_option_byte_reg;
  reg  [7:0]  misc_option_byte_reg;
  reg  [7:0]  fct_reg;
  reg  [15:0] cyc_thr_reg;
  reg  [7:0]  tap_qual_reg;
  reg  [15:0] tap_thr_reg;
  reg  [15:0] bal_thr_reg;
  reg  [7:0]  bal_min_reg;
  reg  [7:0]  bal_int_reg;
  reg  [7:0]  afe_per_reg;
  reg  [7:0]  afe_lim_reg;
  reg  [7:0]  hyst_reg;
  reg  [15:0] dsg_acc_reg;
  reg  [7:0]  afe_tmr_reg;
  reg  [7:0]  afe_cnt_reg;
  reg  [7:0]  bal_tmr_reg;
  reg         once_done_reg;
  reg         chg_cmd_reg;
  reg         dsg_cmd_reg;
  reg  [7:0]  rd_mux;
  reg  [7:0]  nv_addr_next;
  wire        sec;
  wire        run = (state_reg == ST_RUN);
  wire        taper_done;
  wire        sleep_done;
  wire        chg_dly_done;
  wire        dsg_dly_done;
  wire [16:0] tap_floor = {1'b0, I_CHG_VOLT_MV} - {9'h000, tap_qual_reg};
  wire        taper_cond = run && I_CHARGING && !tap_floor[16]
                && (I_PACK_MV >= tap_floor[15:0]) && (I_CURRENT_MA < tap_thr_reg);
  wire [15:0] cell_diff = I_CELL_MAX_MV - I_CELL_MIN_MV;
  wire        chg_want = I_CHG_FET_REQ && !I_OVERTEMP;
  wire        dsg_want = I_DSG_FET_REQ
                && !(I_OVERTEMP && misc_option_byte_reg[`GPCC_MI_OT]);
  wire        fet_switch_delay = misc_option_byte_reg[`GPCC_MI_VOD];
  wire [31:0] rm_prod = I_FCC * ({8'h00, fct_reg} + 16'h0001);

  gpcc_tick #(.DIV(SEC_DIV)) u_tick (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .o_tick  (sec)
  );
  gpcc_secs #(.W(8)) u_taper (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sec   (sec),
    .i_hold  (taper_cond),
    .i_limit (TAPER_CYC[7:0] + 8'h01), // first tick may be partial
    .o_done  (taper_done)
  );
  gpcc_secs #(.W(8)) u_sleep (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sec   (sec),
    .i_hold  (run && I_SMB_LOW && !misc_option_byte_reg[`GPCC_MI_DS]),
    .i_limit (SLEEP_CYC[7:0] + 8'h01), // first tick may be partial
    .o_done  (sleep_done)
  );
  gpcc_secs #(.W(8)) u_chg_dly (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sec   (sec),
    .i_hold  (chg_want != chg_cmd_reg),
    .i_limit (fet_switch_delay ? DELAY_CYC[7:0] + 8'h01 : 8'h00),
    .o_done  (chg_dly_done)
  );
  gpcc_secs #(.W(8)) u_dsg_dly (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_sec   (sec),
    .i_hold  (dsg_want != dsg_cmd_reg),
    .i_limit (fet_switch_delay ? DELAY_CYC[7:0] + 8'h01 : 8'h00),
    .o_done  (dsg_dly_done)
  );

  // storage walk order, one address per index
  always @* begin
    case (ld_idx_reg)
      5'h00: nv_addr_next = `GPCC_ADDR_PACK;
      5'h01: nv_addr_next = `GPCC_ADDR_GAUGE;
      5'h02: nv_addr_next = `GPCC_ADDR_MISC;
      5'h03: nv_addr_next = `GPCC_ADDR_FCT;
      5'h04: nv_addr_next = `GPCC_ADDR_CYC_LO;
      5'h05: nv_addr_next = `GPCC_ADDR_CYC_HI;
      5'h06: nv_addr_next = `GPCC_ADDR_TAPQ;
      5'h07: nv_addr_next = `GPCC_ADDR_TAPT_LO;
      5'h08: nv_addr_next = `GPCC_ADDR_TAPT_HI;
      5'h09: nv_addr_next = `GPCC_ADDR_BAL_LO;
      5'h0A: nv_addr_next = `GPCC_ADDR_BAL_HI;
      5'h0B: nv_addr_next = `GPCC_ADDR_BALMIN;
      5'h0C: nv_addr_next = `GPCC_ADDR_BALINT;
      5'h0D: nv_addr_next = `GPCC_ADDR_AFECHK;
      5'h0E: nv_addr_next = `GPCC_ADDR_AFELIM;
      5'h0F: nv_addr_next = `GPCC_ADDR_HYST;
      default: nv_addr_next = 8'h00;
    endcase
  end

  always @* begin
    case (I_ADDR)
      `GPCC_ADDR_PACK:   rd_mux = pack_option_byte_reg;
      `GPCC_ADDR_GAUGE:  rd_mux = gauge_option_byte_reg;
      `GPCC_ADDR_MISC:   rd_mux = misc_option_byte_reg;
      `GPCC_ADDR_STATUS: rd_mux = {2'h0, O_SLEEP, O_SAFE, O_AFE_FAIL, O_BALANCE,
                                   O_TAPER_TERM, O_READY};
      `GPCC_ADDR_CYCCNT: rd_mux = O_CYCLE_COUNT[7:0];
      default:           rd_mux = 8'h00;
    endcase
  end

  // load and register access
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg             <= ST_LOAD;
      ld_idx_reg            <= 5'h00;
      ld_idx_d_reg          <= 5'h00;
      ld_vld_reg            <= 1'b0;
      O_NV_ADDR             <= 8'h00;
      O_NV_RD               <= 1'b0;
      O_READY               <= 1'b0;
      O_RDATA               <= 8'h00;
      pack_option_byte_reg  <= 8'h00;
      gauge_option_byte_reg <= 8'h00;
      misc_option_byte_reg  <= 8'h00;
      fct_reg               <= 8'h00;
      cyc_thr_reg           <= 16'h0000;
      tap_qual_reg          <= 8'h00;
      tap_thr_reg           <= 16'h0000;
      bal_thr_reg           <= `GPCC_BAL_OFF;
      bal_min_reg           <= 8'h00;
      bal_int_reg           <= 8'h00;
      afe_per_reg           <= 8'h00;
      afe_lim_reg           <= 8'h00;
      hyst_reg              <= 8'h00;
    end else begin
      O_RDATA    <= I_RD ? rd_mux : 8'h00;
      ld_vld_reg <= O_NV_RD;
      ld_idx_d_reg <= ld_idx_reg;
      case (state_reg)
        ST_LOAD: begin
          O_NV_RD   <= (ld_idx_reg <= `GPCC_NV_LAST);
          O_NV_ADDR <= nv_addr_next;
          if (ld_idx_reg <= `GPCC_NV_LAST)
            ld_idx_reg <= ld_idx_reg + 5'h01;
          else if (!ld_vld_reg && !O_NV_RD) begin
            state_reg <= ST_RUN;
            O_READY   <= 1'b1;
          end
        end
        ST_RUN: begin
          O_NV_RD <= 1'b0;
          // reserved bits are stored as written; programmer keeps them zero
          if (I_WR && I_ADDR == `GPCC_ADDR_PACK)  pack_option_byte_reg  <= I_WDATA;
          if (I_WR && I_ADDR == `GPCC_ADDR_GAUGE) gauge_option_byte_reg <= I_WDATA;
          if (I_WR && I_ADDR == `GPCC_ADDR_MISC)  misc_option_byte_reg  <= I_WDATA;
        end
        default: state_reg <= ST_LOAD;
      endcase
      if (ld_vld_reg) begin
        case (ld_idx_d_reg - 5'h01)
          5'h00: pack_option_byte_reg  <= I_NV_DATA;
          5'h01: gauge_option_byte_reg <= I_NV_DATA;
          5'h02: misc_option_byte_reg  <= I_NV_DATA;
          5'h03: fct_reg               <= I_NV_DATA;
          5'h04: cyc_thr_reg[7:0]      <= I_NV_DATA;
          5'h05: cyc_thr_reg[15:8]     <= I_NV_DATA;
          5'h06: tap_qual_reg          <= I_NV_DATA;
          5'h07: tap_thr_reg[7:0]      <= I_NV_DATA;
          5'h08: tap_thr_reg[15:8]     <= I_NV_DATA;
          5'h09: bal_thr_reg[7:0]      <= I_NV_DATA;
          5'h0A: bal_thr_reg[15:8]     <= I_NV_DATA;
          5'h0B: bal_min_reg           <= I_NV_DATA;
          5'h0C: bal_int_reg           <= I_NV_DATA;
          5'h0D: afe_per_reg           <= I_NV_DATA;
          5'h0E: afe_lim_reg           <= I_NV_DATA;
          5'h0F: hyst_reg              <= I_NV_DATA;
          default: hyst_reg            <= hyst_reg;
        endcase
      end
    end
  end

  // option decode, all registered; nothing acts before load completes
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DISPLAY_SOC_SELECT           <= 1'b0;
      O_DISPLAY_SEGMENT_COUNT        <= 3'h5;
      O_LED_ENABLE                   <= 1'b0;
      O_HOST_ALARM_CRC_ENABLE        <= 1'b0;
      O_CHARGER_BROADCAST_CRC_ENABLE <= 1'b0;
      O_BROADCAST_ENABLE             <= 1'b0;
      O_SERIES_CELL_COUNT            <= 3'h4;
      O_COMPENSATED_THRESHOLD_ENABLE <= 1'b0;
      O_END_DISCHARGE_VOLT_SOURCE    <= 1'b0;
      O_SAFETY_OVERVOLT_SOURCE       <= 1'b0;
      O_MIDRANGE_CORRECT             <= 1'b0;
      once_done_reg                  <= 1'b0;
    end else if (run) begin
      O_DISPLAY_SOC_SELECT <= pack_option_byte_reg[`GPCC_PK_DISPLAY_SOC_SELECT];
      case (pack_option_byte_reg[`GPCC_PK_LED_HI:`GPCC_PK_LED_LO])
        2'h1:    O_DISPLAY_SEGMENT_COUNT <= 3'h3;
        2'h2:    O_DISPLAY_SEGMENT_COUNT <= 3'h4;
        default: O_DISPLAY_SEGMENT_COUNT <= 3'h5;
      endcase
      O_LED_ENABLE <= !I_CHARGING || misc_option_byte_reg[`GPCC_MI_CHARGE_TIME_DISPLAY_ENABLE];
      O_HOST_ALARM_CRC_ENABLE <= pack_option_byte_reg[`GPCC_PK_HPE];
      O_CHARGER_BROADCAST_CRC_ENABLE <= pack_option_byte_reg[`GPCC_PK_CPE];
      O_BROADCAST_ENABLE <= !pack_option_byte_reg[`GPCC_PK_SM];
      O_SERIES_CELL_COUNT <= pack_option_byte_reg[`GPCC_PK_CC] ? 3'h3 : 3'h4;
      O_COMPENSATED_THRESHOLD_ENABLE <= gauge_option_byte_reg[`GPCC_GA_COMPENSATED_THRESHOLD_ENABLE];
      O_END_DISCHARGE_VOLT_SOURCE <= gauge_option_byte_reg[`GPCC_GA_END_DISCHARGE_VOLT_SOURCE];
      O_SAFETY_OVERVOLT_SOURCE <= gauge_option_byte_reg[`GPCC_GA_SAFETY_OVERVOLT_SOURCE];
      // one-shot fires on the first request after reset only
      O_MIDRANGE_CORRECT <= I_MIDRANGE_REQ && (gauge_option_byte_reg[`GPCC_GA_MIDRANGE_CORRECT_CONTINUOUS]
                            || (gauge_option_byte_reg[`GPCC_GA_MIDRANGE_CORRECT_ONESHOT] && !once_done_reg));
      if (I_MIDRANGE_REQ && gauge_option_byte_reg[`GPCC_GA_MIDRANGE_CORRECT_ONESHOT])
        once_done_reg <= 1'b1;
    end
  end

  // gauge events and protection
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RM_LOAD      <= 1'b0;
      O_RM_VALUE     <= 16'h0000;
      O_CYCLE_COUNT  <= 16'h0000;
      dsg_acc_reg    <= 16'h0000;
      O_TAPER_TERM   <= 1'b0;
      O_BALANCE      <= 1'b0;
      bal_tmr_reg    <= 8'h00;
      afe_tmr_reg    <= 8'h00;
      afe_cnt_reg    <= 8'h00;
      O_AFE_FAIL     <= 1'b0;
      O_SAFE         <= 1'b0;
      O_SLEEP        <= 1'b0;
      chg_cmd_reg    <= 1'b0;
      dsg_cmd_reg    <= 1'b0;
      O_CHG_FET      <= 1'b0;
      O_DSG_FET      <= 1'b0;
      O_PRECHG_FET   <= 1'b0;
      O_TEMP_SUSPEND <= 1'b0;
    end else if (run) begin
      // fraction = (code+1)/256 of full capacity
      O_RM_LOAD  <= I_FAST_TERM && gauge_option_byte_reg[`GPCC_GA_TERMINATION_CAPACITY_LOAD];
      O_RM_VALUE <= rm_prod[23:8];
      if (I_DSG_MAH_TICK) begin
        if (dsg_acc_reg + 16'h0001 >= cyc_thr_reg && cyc_thr_reg != 16'h0000) begin
          dsg_acc_reg   <= 16'h0000;
          O_CYCLE_COUNT <= O_CYCLE_COUNT + 16'h0001;
        end else
          dsg_acc_reg <= dsg_acc_reg + 16'h0001;
      end
      O_TAPER_TERM <= taper_done;
      // balancing decision held between interval ticks
      if (bal_thr_reg == `GPCC_BAL_OFF) begin
        O_BALANCE   <= 1'b0;
        bal_tmr_reg <= 8'h00;
      end else if (sec) begin
        if (bal_tmr_reg == 8'h00) begin
          bal_tmr_reg <= (bal_int_reg == 8'h00) ? 8'h00 : bal_int_reg - 8'h01;
          O_BALANCE   <= (I_CELL_MAX_MV >= bal_thr_reg)
                         && (cell_diff >= {8'h00, bal_min_reg});
        end else
          bal_tmr_reg <= bal_tmr_reg - 8'h01;
      end
      // periodic integrity check, failures accumulate to the limit
      if (sec) begin
        if (afe_tmr_reg == 8'h00) begin
          afe_tmr_reg <= (afe_per_reg == 8'h00) ? 8'h00 : afe_per_reg - 8'h01;
          if (I_AFE_CHECK_FAIL && afe_cnt_reg != 8'hFF)
            afe_cnt_reg <= afe_cnt_reg + 8'h01;
        end else
          afe_tmr_reg <= afe_tmr_reg - 8'h01;
      end
      if (afe_cnt_reg >= afe_lim_reg && afe_cnt_reg != 8'h00)
        O_AFE_FAIL <= 1'b1;
      O_SAFE <= O_AFE_FAIL && misc_option_byte_reg[`GPCC_MI_AC];
      O_SLEEP <= sleep_done;
      // overtemp gating in chg_want and dsg_want
      if (chg_dly_done) chg_cmd_reg <= chg_want;
      if (dsg_dly_done) dsg_cmd_reg <= dsg_want;
      O_CHG_FET <= chg_cmd_reg;
      O_DSG_FET <= dsg_cmd_reg;
      O_PRECHG_FET <= misc_option_byte_reg[`GPCC_MI_PHG] && I_PRECHG_COND;
      if (I_TEMP_DK >= I_MAXTEMP_DK)
        O_TEMP_SUSPEND <= 1'b1;
      else if (I_TEMP_DK <= `GPCC_TEMP_CLR
               || I_TEMP_DK + {8'h00, hyst_reg} * 16'd10 <= I_MAXTEMP_DK)
        O_TEMP_SUSPEND <= 1'b0;
    end
  end
endmodule

// >>> shared/gpcc_regs.vh
// Behaviour
// - on termination load capacity with programmed fraction
// - count cycle after threshold mAh discharged
// - taper end after 40 s qualified low current
// - balance when threshold and difference reached, interval
// - threshold 65535 disables balancing
// - bit7 picks relative or absolute display
// - segment field picks three, four, five LEDs
// - bit4 adds check byte to host alarms
// - bit3 adds check byte to charger broadcasts
// - bit2 stops all broadcasts, mode cannot override
// - cell field zero four cells, one three
// - gauge bit4 selects computed discharge thresholds
// - gauge bit3 selects pack or lowest cell
// - gauge bit2 selects overvoltage source
// - continuous or once-after-reset midrange correction
// - integrity check periodic, flag after limit failures
// - misc bit5 lets integrity failure assert safety
// - sleep after 2 s low bus unless inhibited
// - overtemp cuts charge, discharge only if enabled
// - misc bit2 allows LEDs while charging
// - misc bit1 enables precharge switch
// - misc bit0 delays switch changes one second
// - clear overtemp suspension by hysteresis or 43.0 C
`ifndef GPCC_REGS_VH
`define GPCC_REGS_VH
`define GPCC_ADDR_PACK     8'h28
`define GPCC_ADDR_GAUGE    8'h29
`define GPCC_ADDR_MISC     8'h2A
`define GPCC_ADDR_FCT      8'h46
`define GPCC_ADDR_CYC_LO   8'h37
`define GPCC_ADDR_CYC_HI   8'h38
`define GPCC_ADDR_TAPQ     8'h4A
`define GPCC_ADDR_TAPT_LO  8'h48
`define GPCC_ADDR_TAPT_HI  8'h49
`define GPCC_ADDR_BAL_LO   8'hD9
`define GPCC_ADDR_BAL_HI   8'hDA
`define GPCC_ADDR_BALMIN   8'hDB
`define GPCC_ADDR_BALINT   8'hDC
`define GPCC_ADDR_AFECHK   8'hE4
`define GPCC_ADDR_AFELIM   8'hD3
`define GPCC_ADDR_HYST     8'h55
`define GPCC_ADDR_STATUS   8'hF0
`define GPCC_ADDR_CYCCNT   8'hF1
`define GPCC_PK_DISPLAY_SOC_SELECT      7
`define GPCC_PK_LED_HI     6
`define GPCC_PK_LED_LO     5
`define GPCC_PK_HPE        4
`define GPCC_PK_CPE        3
`define GPCC_PK_SM         2
`define GPCC_PK_CC         0
`define GPCC_GA_TERMINATION_CAPACITY_LOAD      6
`define GPCC_GA_COMPENSATED_THRESHOLD_ENABLE       4
`define GPCC_GA_END_DISCHARGE_VOLT_SOURCE       3
`define GPCC_GA_SAFETY_OVERVOLT_SOURCE      2
`define GPCC_GA_MIDRANGE_CORRECT_CONTINUOUS       1
`define GPCC_GA_MIDRANGE_CORRECT_ONESHOT       0
`define GPCC_MI_AC         5
`define GPCC_MI_DS         4
`define GPCC_MI_OT         3
`define GPCC_MI_CHARGE_TIME_DISPLAY_ENABLE      2
`define GPCC_MI_PHG        1
`define GPCC_MI_VOD        0
`define GPCC_BAL_OFF       16'hFFFF
`define GPCC_TEMP_CLR      16'h01AE
`define GPCC_CLK_HZ        50000000
`define GPCC_TAPER_S       40
`define GPCC_SLEEP_S       2
`define GPCC_DELAY_S       1
`define GPCC_NV_LAST       5'h0F
`endif

// >>> rtl/gpcc_tick.v
`timescale 1ns/1ps
// one-cycle enable every DIV clocks
module gpcc_tick #(
  parameter DIV = 50000000
) (
  input  wire i_clk,
  input  wire i_rst_n,
  output reg  o_tick
);
  reg [31:0] cnt_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 32'h0;
      o_tick  <= 1'b0;
    end else if (cnt_reg == DIV - 1) begin
      cnt_reg <= 32'h0;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      o_tick  <= 1'b0;
    end
  end
endmodule

// >>> rtl/gpcc_secs.v
`timescale 1ns/1ps
// counts seconds while a condition holds; done once count reached
module gpcc_secs #(
  parameter W = 8
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_sec,
  input  wire         i_hold,
  input  wire [W-1:0] i_limit,
  output wire         o_done
);
  reg [W-1:0] cnt_reg;
  assign o_done = i_hold && (cnt_reg >= i_limit);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      cnt_reg <= {W{1'b0}};
    else if (!i_hold)
      cnt_reg <= {W{1'b0}};
    else if (i_sec && cnt_reg < i_limit)
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
  end
endmodule

// >>> sim/gpcc_nv_model.sv
`timescale 1ns/1ps
module gpcc_nv_model (
  input  wire       i_clk,
  input  wire [7:0] i_addr,
  input  wire       i_rd,
  output reg  [7:0] o_data
);
  reg [7:0] mem [0:255];
  initial o_data = 8'h00;
  // a byte is valid only in the cycle after its strobe; at other times the
  // released line shows the inverse of its last value, so a late sample fails
  always @(posedge i_clk) begin
    o_data <= i_rd ? mem[i_addr] : ~o_data;
  end
endmodule

// >>> sim/gpcc_chk_assertions.sv
`timescale 1ns/1ps
module gpcc_chk #(
  parameter SEC_DIV = 50000000
) (
  input wire        I_CLK,
  input wire        I_RST_N,
  input wire [7:0]  I_ADDR,
  input wire        I_RD,
  input wire        I_FAST_TERM,
  input wire        I_OVERTEMP,
  input wire        I_SMB_LOW,
  input wire        I_CHARGING,
  input wire [7:0]  O_RDATA,
  input wire        O_READY,
  input wire        O_DISPLAY_SOC_SELECT,
  input wire [2:0]  O_DISPLAY_SEGMENT_COUNT,
  input wire [2:0]  O_SERIES_CELL_COUNT,
  input wire        O_RM_LOAD,
  input wire [15:0] O_CYCLE_COUNT,
  input wire        O_TAPER_TERM,
  input wire        O_AFE_FAIL,
  input wire        O_SAFE,
  input wire        O_SLEEP,
  input wire        O_CHG_FET
);
  localparam int OT_WAIT   = 2 * SEC_DIV + 8;
  localparam int TAPER_MIN = 40 * SEC_DIV;
  reg [31:0] ot_cnt;
  reg [31:0] low_cnt;
  reg [31:0] chg_cnt;
  // run lengths of held inputs; second-based waits are judged by counts
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ot_cnt  <= 32'h0;
      low_cnt <= 32'h0;
      chg_cnt <= 32'h0;
    end else begin
      ot_cnt  <= I_OVERTEMP ? ot_cnt + 32'h1 : 32'h0;
      low_cnt <= I_SMB_LOW ? low_cnt + 32'h1 : 32'h0;
      chg_cnt <= I_CHARGING ? chg_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_rd_pack;
    O_READY && I_RD && I_ADDR == 8'h28;
  endsequence
  sequence s_pack_cc_legal;
    s_rd_pack ##1 !O_RDATA[1];
  endsequence
  property p_soc;
    s_rd_pack |=> O_DISPLAY_SOC_SELECT == O_RDATA[7];
  endproperty
  property p_seg;
    s_rd_pack |=> O_DISPLAY_SEGMENT_COUNT == (O_RDATA[6:5] == 2'h1 ? 3'h3 :
                                              O_RDATA[6:5] == 2'h2 ? 3'h4 : 3'h5);
  endproperty
  property p_cells;
    s_pack_cc_legal |-> O_SERIES_CELL_COUNT == (O_RDATA[0] ? 3'h3 : 3'h4);
  endproperty
  property p_rm_load;
    O_RM_LOAD |-> $past(I_FAST_TERM);
  endproperty
  property p_cycle;
    $changed(O_CYCLE_COUNT) |-> O_CYCLE_COUNT == $past(O_CYCLE_COUNT) + 16'h0001;
  endproperty
  property p_taper;
    $rose(O_TAPER_TERM) |-> chg_cnt >= TAPER_MIN;
  endproperty
  property p_safe;
    O_SAFE |-> O_AFE_FAIL;
  endproperty
  property p_sleep;
    $rose(O_SLEEP) |-> low_cnt >= 2 * SEC_DIV;
  endproperty
  property p_ot_chg;
    ot_cnt >= OT_WAIT |-> !O_CHG_FET;
  endproperty
  a_soc: assert property (p_soc) else $error("display source differs from byte");
  a_seg: assert property (p_seg) else $error("segment count wrong");
  a_cells: assert property (p_cells) else $error("series cell count wrong");
  a_rm_load: assert property (p_rm_load) else $error("capacity load without termination");
  a_cycle: assert property (p_cycle) else $error("cycle count stepped by other than one");
  a_taper: assert property (p_taper) else $error("taper end came too early");
  a_safe: assert property (p_safe) else $error("safety output without front-end fail");
  a_sleep: assert property (p_sleep) else $error("sleep entered too early");
  a_ot_chg: assert property (p_ot_chg) else $error("charge switch on in overtemperature");
endmodule
bind gpcc_top gpcc_chk #(.SEC_DIV(SEC_DIV)) u_chk (.*);

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        I_CLK, I_RST_N, I_WR, I_RD, I_CHARGING, I_FAST_TERM, I_DSG_MAH_TICK;
  logic        I_OVERTEMP, I_AFE_CHECK_FAIL, I_SMB_LOW, I_PRECHG_COND, I_MIDRANGE_REQ;
  logic        I_CHG_FET_REQ, I_DSG_FET_REQ, O_NV_RD, O_READY, O_DISPLAY_SOC_SELECT;
  logic [7:0]  I_ADDR, I_WDATA, I_NV_DATA, O_NV_ADDR, O_RDATA, v, d;
  logic [15:0] I_PACK_MV, I_CHG_VOLT_MV, I_CURRENT_MA, I_CELL_MAX_MV, I_CELL_MIN_MV;
  logic [15:0] I_FCC, I_TEMP_DK, I_MAXTEMP_DK, O_RM_VALUE, O_CYCLE_COUNT;
  logic [2:0]  O_DISPLAY_SEGMENT_COUNT, O_SERIES_CELL_COUNT;
  logic        O_LED_ENABLE, O_HOST_ALARM_CRC_ENABLE, O_CHARGER_BROADCAST_CRC_ENABLE;
  logic        O_BROADCAST_ENABLE, O_COMPENSATED_THRESHOLD_ENABLE, O_MIDRANGE_CORRECT;
  logic        O_END_DISCHARGE_VOLT_SOURCE, O_SAFETY_OVERVOLT_SOURCE, O_RM_LOAD;
  logic        O_TAPER_TERM, O_BALANCE, O_AFE_FAIL, O_SAFE, O_SLEEP, O_CHG_FET;
  logic        O_DSG_FET, O_PRECHG_FET, O_TEMP_SUSPEND;
  int          n_errors, tests_run, n, i;
  localparam logic [7:0] PACK_NV  = 8'h35;
  localparam logic [7:0] GAUGE_NV = 8'h5A;
  gpcc_top #(.SEC_DIV(10)) dut (.*);
  gpcc_nv_model nv (.i_clk(I_CLK), .i_addr(O_NV_ADDR), .i_rd(O_NV_RD), .o_data(I_NV_DATA));
  always #10 I_CLK = ~I_CLK;
  function automatic logic [2:0] seg_exp(input logic [1:0] c);
    seg_exp = (c == 2'h1) ? 3'h3 : (c == 2'h2) ? 3'h4 : 3'h5;
  endfunction
  function automatic logic [15:0] rm_exp(input logic [15:0] f, input logic [7:0] c);
    rm_exp = 16'((32'(f) * (32'(c) + 32'h1)) >> 8);
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task tmo(input int lim);
    if (n >= lim) begin
      n_errors++;
      give_verdict;
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge I_CLK);
    I_ADDR  <= a;
    I_WDATA <= w;
    I_WR    <= 1'b1;
    @(posedge I_CLK);
    I_WR    <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CLK);
    I_RD   <= 1'b0;
    #1;
    r = O_RDATA;
  endtask
  task mset(input logic [7:0] m);
    wr(8'h2A, m & 8'hBF);
    step(4);
  endtask
  task tcase(input logic [15:0] t, input logic e);
    I_TEMP_DK <= t;
    step(4);
    chk(O_TEMP_SUSPEND, e);
  endtask
  task wait_ready;
    for (n = 0; n < 100 && O_READY !== 1'b1; n++) @(posedge I_CLK);
    tmo(100);
    step(1);
  endtask
  initial begin
    {I_CLK, I_RST_N, I_WR, I_RD, I_CHARGING, I_FAST_TERM, I_DSG_MAH_TICK} = '0;
    {I_OVERTEMP, I_AFE_CHECK_FAIL, I_SMB_LOW, I_PRECHG_COND, I_MIDRANGE_REQ} = '0;
    {I_CHG_FET_REQ, I_DSG_FET_REQ, I_ADDR, I_WDATA} = '0;
    {I_PACK_MV, I_CHG_VOLT_MV, I_CURRENT_MA} = {16'h3138, 16'h3138, 16'h01F4};
    {I_CELL_MAX_MV, I_CELL_MIN_MV, I_FCC} = {16'h1068, 16'h0FA0, 16'h03E8};
    {I_TEMP_DK, I_MAXTEMP_DK, n_errors, tests_run} = {16'h00FA, 16'h01F4, 64'h0};
    v = 8'($urandom(75));
    for (i = 0; i < 256; i++) nv.mem[i] = 8'h00;
    {nv.mem[8'h28], nv.mem[8'h29], nv.mem[8'h46]} = {PACK_NV, GAUGE_NV, 8'h7F};
    {nv.mem[8'h37], nv.mem[8'h4A], nv.mem[8'h48]} = {8'h03, 8'h32, 8'h64};
    {nv.mem[8'hD9], nv.mem[8'hDA], nv.mem[8'hDB]} = {8'hFF, 8'hFF, 8'h0A};
    {nv.mem[8'hDC], nv.mem[8'hE4], nv.mem[8'hD3], nv.mem[8'h55]} = 32'h02020205;
    repeat (5) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    wait_ready;
    rd(8'h28, d);
    chk(d, PACK_NV);
    rd(8'h29, d);
    chk(d, GAUGE_NV);
    rd(8'h00, d);
    chk(d, 8'h00);
    for (i = 0; i < 12; i++) begin
      v = 8'($urandom());
      v[6:5] = i[1:0];
      v[1] = 1'b0;
      wr(8'h28, v);
      step(3);
      chk(O_DISPLAY_SOC_SELECT, v[7]);
      chk(O_DISPLAY_SEGMENT_COUNT, seg_exp(v[6:5]));
      chk(O_HOST_ALARM_CRC_ENABLE, v[4]);
      chk(O_CHARGER_BROADCAST_CRC_ENABLE, v[3]);
      chk(O_BROADCAST_ENABLE, !v[2]);
      chk(O_SERIES_CELL_COUNT, v[0] ? 3'h3 : 3'h4);
      rd(8'h28, d);
      chk(d, v);
    end
    I_MIDRANGE_REQ <= 1'b1;
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom()) & 8'h7F;
      wr(8'h29, v);
      step(3);
      chk(O_COMPENSATED_THRESHOLD_ENABLE, v[4]);
      chk(O_END_DISCHARGE_VOLT_SOURCE, v[3]);
      chk(O_SAFETY_OVERVOLT_SOURCE, v[2]);
      chk(O_MIDRANGE_CORRECT, v[1]);
    end
    I_FCC <= 16'($urandom());
    wr(8'h29, 8'h40);
    I_FAST_TERM <= 1'b1;
    step(3);
    chk(O_RM_LOAD, 1'b1);
    chk(O_RM_VALUE, rm_exp(I_FCC, 8'h7F));
    I_FAST_TERM <= 1'b0;
    wr(8'h29, 8'h00);
    I_FAST_TERM <= 1'b1;
    step(3);
    chk(O_RM_LOAD, 1'b0);
    I_FAST_TERM <= 1'b0;
    repeat (7) begin
      @(posedge I_CLK);
      I_DSG_MAH_TICK <= 1'b1;
      @(posedge I_CLK);
      I_DSG_MAH_TICK <= 1'b0;
    end
    step(3);
    chk(O_CYCLE_COUNT, 16'h0002);
    rd(8'hF1, d);
    chk(d, 8'h02);
    I_CHARGING <= 1'b1;
    mset(8'h00);
    chk(O_LED_ENABLE, 1'b0);
    mset(8'h04);
    chk(O_LED_ENABLE, 1'b1);
    I_PRECHG_COND <= 1'b1;
    mset(8'h02);
    chk(O_PRECHG_FET, 1'b1);
    mset(8'h00);
    chk(O_PRECHG_FET, 1'b0);
    {I_CHG_FET_REQ, I_DSG_FET_REQ, I_OVERTEMP} <= 3'h7;
    step(30);
    chk(O_CHG_FET, 1'b0);
    chk(O_DSG_FET, 1'b1);
    mset(8'h08);
    chk(O_DSG_FET, 1'b0);
    mset(8'h01);
    I_OVERTEMP <= 1'b0;
    step(2);
    chk(O_CHG_FET, 1'b0);
    for (n = 0; n < 40 && O_CHG_FET !== 1'b1; n++) @(posedge I_CLK);
    tmo(40);
    tcase(16'h01FE, 1'b1);
    tcase(16'h01C7, 1'b1);
    tcase(16'h01C1, 1'b0);
    I_MAXTEMP_DK <= 16'h01B8;
    tcase(16'h01C2, 1'b1);
    tcase(16'h01AF, 1'b1);
    tcase(16'h01AE, 1'b0);
    mset(8'h00);
    I_AFE_CHECK_FAIL <= 1'b1;
    for (n = 0; n < 200 && O_AFE_FAIL !== 1'b1; n++) @(posedge I_CLK);
    tmo(200);
    chk(n >= 15, 1'b1);
    step(2);
    chk(O_SAFE, 1'b0);
    mset(8'h20);
    chk(O_SAFE, 1'b1);
    I_AFE_CHECK_FAIL <= 1'b0;
    I_CURRENT_MA <= 16'h0032;
    for (n = 0; n < 600 && O_TAPER_TERM !== 1'b1; n++) @(posedge I_CLK);
    tmo(600);
    chk(n >= 400, 1'b1);
    mset(8'h10);
    {I_SMB_LOW, I_CELL_MAX_MV} <= 17'h1FFFF;
    step(60);
    chk(O_SLEEP, 1'b0);
    mset(8'h00);
    for (n = 0; n < 100 && O_SLEEP !== 1'b1; n++) @(posedge I_CLK);
    tmo(100);
    chk(n >= 15, 1'b1);
    chk(O_BALANCE, 1'b0);
    {nv.mem[8'hD9], nv.mem[8'hDA]} = 16'hA00F;
    {I_SMB_LOW, I_CELL_MAX_MV} <= 17'h01068;
    I_RST_N <= 1'b0;
    step(3);
    I_RST_N <= 1'b1;
    wait_ready;
    for (n = 0; n < 100 && O_BALANCE !== 1'b1; n++) @(posedge I_CLK);
    tmo(100);
    I_CELL_MIN_MV <= 16'h1064;
    for (n = 0; n < 100 && O_BALANCE !== 1'b0; n++) @(posedge I_CLK);
    tmo(100);
    give_verdict;
  end
endmodule
